//--- pkg/bld_regs_defs.vh
`ifndef BLD_REGS_DEFS_VH
`define BLD_REGS_DEFS_VH

// register offsets
`define BLD_ADDR_FLASH_SETTING  8'h0B
`define BLD_ADDR_AUTOFREQ_UPPER_LEVEL        8'h0C
`define BLD_ADDR_AUTOFREQ_LOWER_LEVEL         8'h0D
`define BLD_ADDR_FAULT_ONE      8'h0E
`define BLD_ADDR_FAULT_TWO      8'h0F

// reset values
`define BLD_RST_FLASH_SETTING   8'h58
`define BLD_RST_AUTOFREQ_UPPER_LEVEL         8'h80
`define BLD_RST_AUTOFREQ_LOWER_LEVEL          8'h10
`define BLD_RST_FAULT_ONE       8'h00
`define BLD_RST_FAULT_TWO       8'h00

// flash setting fields
`define BLD_FLTO_MSB            7
`define BLD_FLTO_LSB            4
`define BLD_FLCUR_MSB           3
`define BLD_FLCUR_LSB           0

// fault flag bit positions, register one
`define BLD_F1_CH1_OPEN         7
`define BLD_F1_CH2_OPEN         6
`define BLD_F1_CH3_OPEN         5
`define BLD_F1_CH1_SHORT        4
`define BLD_F1_CH2_SHORT        3
`define BLD_F1_CH3_SHORT        2
`define BLD_F1_OCP              1
`define BLD_F1_OTP              0

// fault flag bit positions, register two
`define BLD_F2_OVP              7
`define BLD_F2_UVLO             6
`define BLD_F2_FLASH_EXPIRY     5
`define BLD_F2_WRITABLE_MASK    8'hE0

// timing: timeout step in ms and clock rate in kHz
`define BLD_TIMEOUT_STEP_MS     100
`define BLD_CLK_KHZ             10000
`define BLD_STEP_CYCLES         (`BLD_TIMEOUT_STEP_MS * `BLD_CLK_KHZ)

`endif

//--- rtl/bld_flash_fault_regs.v
`timescale 1ns/1ps
`include "bld_regs_defs.vh"

module bld_flash_fault_regs
#(
   parameter STEP_CYCLES = `BLD_STEP_CYCLES
)
(
   input  wire       ref_clk,
   input  wire       reset,
   input  wire       reg_wr_en,
   input  wire       reg_rd_en,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wr_data,
   output reg  [7:0] reg_rd_data,
   input  wire       flash_request,
   output wire       flash_active,
   output wire [3:0] flash_current_code,
   output wire [7:0] autofreq_upper_level,
   output wire [7:0] autofreq_lower_level,
   input  wire [2:0] open_fault_in,
   input  wire [2:0] short_fault_in,
   input  wire       ocp_in,
   input  wire       otp_in,
   input  wire       ovp_in,
   input  wire       uvlo_in
);

   // step counter end point, cut to the counter width
   localparam [31:0] STEP_LAST = STEP_CYCLES - 1;

   // register storage and next values
   reg  [7:0]  flash_setting_q;
   reg  [7:0]  autofreq_upper_level_q;
   reg  [7:0]  autofreq_lower_level_q;
   reg  [7:0]  fault_one_q;
   reg  [7:0]  fault_two_q;
   reg  [7:0]  fault_one_d;
   reg  [7:0]  fault_two_d;

   // flash timer state
   reg  [31:0] step_cnt_q;
   reg  [3:0]  step_num_q;
   reg         flash_on_q;
   reg         expired_q;

   // two-flop synchroniser stages
   reg  [2:0]  open_s1_q;
   reg  [2:0]  open_s2_q;
   reg  [2:0]  short_s1_q;
   reg  [2:0]  short_s2_q;
   reg  [3:0]  prot_s1_q;
   reg  [3:0]  prot_s2_q;
   reg         req_s1_q;
   reg         req_s2_q;

   // decoded fields, events and strobes
   wire [3:0]  flash_timeout_select;
   wire        timed_flash;
   wire        expire_evt;
   wire [7:0]  fault_one_set;
   wire [7:0]  fault_two_set;
   wire        wr_f1;
   wire        wr_f2;

   assign flash_timeout_select = flash_setting_q[`BLD_FLTO_MSB:`BLD_FLTO_LSB];
   assign flash_current_code   = flash_setting_q[`BLD_FLCUR_MSB:`BLD_FLCUR_LSB];
   assign autofreq_upper_level = autofreq_upper_level_q;
   assign autofreq_lower_level = autofreq_lower_level_q;
   assign flash_active         = flash_on_q;

   // two-flop synchronisers for pins from the analog side
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         open_s1_q  <= 3'h0;
         open_s2_q  <= 3'h0;
         short_s1_q <= 3'h0;
         short_s2_q <= 3'h0;
         prot_s1_q  <= 4'h0;
         prot_s2_q  <= 4'h0;
         req_s1_q   <= 1'b0;
         req_s2_q   <= 1'b0;
      end
      else
      begin
         open_s1_q  <= open_fault_in;
         open_s2_q  <= open_s1_q;
         short_s1_q <= short_fault_in;
         short_s2_q <= short_s1_q;
         prot_s1_q  <= {ocp_in, otp_in, ovp_in, uvlo_in};
         prot_s2_q  <= prot_s1_q;
         req_s1_q   <= flash_request;
         req_s2_q   <= req_s1_q;
      end
   end

   // code zero leaves the flash untimed
   assign timed_flash = (flash_timeout_select != 4'h0);

   // flash timer: counts 100 ms steps from the edge that starts the flash,
   // so the pulse lasts exactly code steps; a nonzero code at or below the steps done ends it at once
   assign expire_evt = flash_on_q && timed_flash
                       && (step_num_q >= flash_timeout_select);

   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         step_cnt_q <= 32'h0;
         step_num_q <= 4'h0;
         flash_on_q <= 1'b0;
         expired_q  <= 1'b0;
      end
      else if (!req_s2_q)
      begin
         step_cnt_q <= 32'h0;
         step_num_q <= 4'h0;
         flash_on_q <= 1'b0;
         expired_q  <= 1'b0;
      end
      else if (expire_evt)
      begin
         flash_on_q <= 1'b0;
         expired_q  <= 1'b1;
      end
      else if (!expired_q)
      begin
         flash_on_q <= 1'b1;
         if (timed_flash)
         begin
            if (step_cnt_q == STEP_LAST)
            begin
               step_cnt_q <= 32'h0;
               step_num_q <= step_num_q + 4'h1;
            end
            else
            begin
               step_cnt_q <= step_cnt_q + 32'h1;
            end
         end
      end
   end

   // hardware set sources per flag bit
   assign fault_one_set = {open_s2_q, short_s2_q, prot_s2_q[3:2]};
   assign fault_two_set = {prot_s2_q[1:0], expire_evt, 5'h00};
   assign wr_f1 = reg_wr_en && (reg_addr == `BLD_ADDR_FAULT_ONE);
   assign wr_f2 = reg_wr_en && (reg_addr == `BLD_ADDR_FAULT_TWO);

   // sticky flags: writing zero clears a bit, a set in the same cycle wins
   always @*
   begin
      fault_one_d = fault_one_q;
      fault_two_d = fault_two_q;
      if (wr_f1)
      begin
         fault_one_d = fault_one_q & reg_wr_data;
      end
      if (wr_f2)
      begin
         fault_two_d = fault_two_q & (reg_wr_data | ~`BLD_F2_WRITABLE_MASK);
      end
      fault_one_d = fault_one_d | fault_one_set;
      fault_two_d = (fault_two_d | fault_two_set) & `BLD_F2_WRITABLE_MASK;
   end

   // register writes
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         flash_setting_q <= `BLD_RST_FLASH_SETTING;
         autofreq_upper_level_q       <= `BLD_RST_AUTOFREQ_UPPER_LEVEL;
         autofreq_lower_level_q        <= `BLD_RST_AUTOFREQ_LOWER_LEVEL;
         fault_one_q     <= `BLD_RST_FAULT_ONE;
         fault_two_q     <= `BLD_RST_FAULT_TWO;
      end
      else
      begin
         fault_one_q <= fault_one_d;
         fault_two_q <= fault_two_d;
         if (reg_wr_en)
         begin
            case (reg_addr)
               `BLD_ADDR_FLASH_SETTING: flash_setting_q <= reg_wr_data;
               `BLD_ADDR_AUTOFREQ_UPPER_LEVEL:       autofreq_upper_level_q       <= reg_wr_data;
               `BLD_ADDR_AUTOFREQ_LOWER_LEVEL:        autofreq_lower_level_q        <= reg_wr_data;
               default:                 ;
            endcase
         end
      end
   end

   // registered read data, zero for unmapped offsets
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         reg_rd_data <= 8'h00;
      end
      else if (reg_rd_en)
      begin
         case (reg_addr)
            `BLD_ADDR_FLASH_SETTING: reg_rd_data <= flash_setting_q;
            `BLD_ADDR_AUTOFREQ_UPPER_LEVEL:       reg_rd_data <= autofreq_upper_level_q;
            `BLD_ADDR_AUTOFREQ_LOWER_LEVEL:        reg_rd_data <= autofreq_lower_level_q;
            `BLD_ADDR_FAULT_ONE:     reg_rd_data <= fault_one_q;
            `BLD_ADDR_FAULT_TWO:     reg_rd_data <= fault_two_q;
            default:                 reg_rd_data <= 8'h00;
         endcase
      end
   end

endmodule

//--- tb/faf_host.sv
`timescale 1ns/1ps
// register host on the parallel strobes, changes after the falling edge
module faf_host
(
   input  wire       ref_clk,
   input  wire [7:0] rd_data,
   output reg        wr_en,
   output reg        rd_en,
   output reg  [7:0] addr,
   output reg  [7:0] wdata
);
   initial {wr_en, rd_en, addr, wdata} = 18'h0;
   // one write strobe cycle
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(negedge ref_clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge ref_clk);
      wr_en = 1'b0;
   end
   endtask
   // one read strobe cycle, data taken once registered
   task rd(input [7:0] a, output [7:0] d);
   begin
      @(negedge ref_clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge ref_clk);
      rd_en = 1'b0;
      @(negedge ref_clk);
      d = rd_data;
   end
   endtask
endmodule

//--- tb/faf_monitor.sv
`timescale 1ns/1ps
module faf_monitor
(
   input wire       ref_clk,
   input wire       reset,
   input wire       reg_wr_en,
   input wire       reg_rd_en,
   input wire [7:0] reg_rd_data,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wr_data,
   input wire       flash_request,
   input wire       flash_active,
   input wire [3:0] flash_current_code,
   input wire [7:0] autofreq_upper_level,
   input wire [7:0] autofreq_lower_level
);
   a_code_rst_val: assert property (@(posedge ref_clk) reset |-> flash_current_code == 4'h8)
      else $error("flash current code not at reset value");
   a_upper_rst_val: assert property (@(posedge ref_clk) reset |-> autofreq_upper_level == 8'h80)
      else $error("upper level not at reset value");
   a_lower_rst_val: assert property (@(posedge ref_clk) reset |-> autofreq_lower_level == 8'h10)
      else $error("lower level not at reset value");
   a_flash_rst_off: assert property (@(posedge ref_clk) reset |-> !flash_active)
      else $error("flash on during reset");
   a_code_wr_show: assert property (@(posedge ref_clk) disable iff (reset)
      reg_wr_en && reg_addr == 8'h0B |=> flash_current_code == $past(reg_wr_data[3:0]))
      else $error("current code not updated by write");
   a_upper_wr_show: assert property (@(posedge ref_clk) disable iff (reset)
      reg_wr_en && reg_addr == 8'h0C |=> autofreq_upper_level == $past(reg_wr_data))
      else $error("upper level not updated by write");
   a_lower_wr_show: assert property (@(posedge ref_clk) disable iff (reset)
      reg_wr_en && reg_addr == 8'h0D |=> autofreq_lower_level == $past(reg_wr_data))
      else $error("lower level not updated by write");
   a_flash_req_gone: assert property (@(posedge ref_clk) disable iff (reset)
      (!flash_request) [*4] |-> !flash_active)
      else $error("flash on without request");
   a_rd_rsvd_zero: assert property (@(posedge ref_clk) disable iff (reset)
      reg_rd_en && reg_addr == 8'h0F |=> reg_rd_data[4:0] == 5'h00)
      else $error("reserved flag bits read nonzero");
   a_upper_hold: assert property (@(posedge ref_clk) disable iff (reset)
      !(reg_wr_en && reg_addr == 8'h0C) |=> $stable(autofreq_upper_level))
      else $error("upper level changed without write");
endmodule
bind bld_flash_fault_regs faf_monitor mon (.ref_clk(ref_clk), .reset(reset),
   .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
   .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
   .flash_request(flash_request), .flash_active(flash_active),
   .flash_current_code(flash_current_code), .autofreq_upper_level(autofreq_upper_level),
   .autofreq_lower_level(autofreq_lower_level));

//--- tb/flash_autofreq_fault_flag_regs_tb.sv
`timescale 1ns/1ps
module flash_autofreq_fault_flag_regs_tb;
   reg        ref_clk = 0;
   reg        reset = 0;
   reg        flash_request = 0;
   reg  [2:0] open_in = 0;
   reg  [2:0] short_in = 0;
   reg  [3:0] prot_in = 0;
   wire       wr_en, rd_en, flash_active;
   wire [7:0] addr, wdata, rd_data, up_lvl, lo_lvl;
   wire [3:0] cur_code;
   reg  [7:0] d;
   integer    fails = 0, comparisons = 0, n;
   always #50 ref_clk = ~ref_clk;
   faf_host host (.ref_clk(ref_clk), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata));
   bld_flash_fault_regs #(.STEP_CYCLES(10)) uut (.ref_clk(ref_clk), .reset(reset),
      .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata),
      .reg_rd_data(rd_data), .flash_request(flash_request), .flash_active(flash_active),
      .flash_current_code(cur_code), .autofreq_upper_level(up_lvl),
      .autofreq_lower_level(lo_lvl), .open_fault_in(open_in), .short_fault_in(short_in),
      .ocp_in(prot_in[3]), .otp_in(prot_in[2]), .ovp_in(prot_in[1]), .uvlo_in(prot_in[0]));
   // compare and count
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
   begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   end
   endtask
   // read a register and compare
   task rchk(input [7:0] a, input [7:0] exp);
   begin
      host.rd(a, d);
      chk("register", d, exp);
   end
   endtask
   task summarize;
   begin
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   // reset values and plain read-write places
   task t_regs;
   begin
      rchk(8'h0B, 8'h58);
      rchk(8'h0C, 8'h80);
      rchk(8'h0D, 8'h10);
      rchk(8'h0E, 8'h00);
      rchk(8'h0F, 8'h00);
      host.wr(8'h0C, 8'hA5);
      host.wr(8'h0D, 8'h5A);
      host.wr(8'h0B, 8'h1F);
      rchk(8'h0C, 8'hA5);
      rchk(8'h0D, 8'h5A);
      chk("code", {4'h0, cur_code}, 8'h0F);
      chk("upper level", up_lvl, 8'hA5);
      chk("lower level", lo_lvl, 8'h5A);
   end
   endtask
   // sticky flags, reserved bits, clear by writing zero
   task t_faults;
   begin
      {open_in, short_in, prot_in} = 10'h3FF;
      repeat (4) @(negedge ref_clk);
      {open_in, short_in, prot_in} = 10'h000;
      rchk(8'h0E, 8'hFF);
      rchk(8'h0F, 8'hC0);
      host.wr(8'h0F, 8'hFF);
      rchk(8'h0F, 8'hC0);
      host.wr(8'h0E, 8'h00);
      host.wr(8'h0F, 8'h00);
      rchk(8'h0E, 8'h00);
      rchk(8'h0F, 8'h00);
   end
   endtask
   // code 1 flash ends after one step and flags expiry
   task t_flash;
   begin
      flash_request = 1'b1;
      for (n = 0; n < 8 && !flash_active; n = n + 1) @(negedge ref_clk);
      if (flash_active !== 1'b1)
      begin
         fails = fails + 1;
         summarize;
      end
      for (n = 0; n < 40 && flash_active; n = n + 1) @(negedge ref_clk);
      chk("flash cycles", n[7:0], 8'h0A);
      rchk(8'h0F, 8'h20);
      flash_request = 1'b0;
      repeat (4) @(negedge ref_clk);
      rchk(8'h0F, 8'h20);
      host.wr(8'h0F, 8'h00);
      host.wr(8'h0B, 8'h0F);
      flash_request = 1'b1;
      repeat (40) @(negedge ref_clk);
      chk("untimed flash", {7'h00, flash_active}, 8'h01);
      rchk(8'h0F, 8'h00);
      flash_request = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("flash off", {7'h00, flash_active}, 8'h00);
   end
   endtask
   initial
   begin
      @(negedge ref_clk);
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      t_regs;
      t_faults;
      t_flash;
      summarize;
   end
endmodule
